// ==== logic/secl_pkg.sv ====
package secl_pkg;

   // -----------------------------------------------------------------
   // Identity and memory layout
   // -----------------------------------------------------------------
   localparam logic [3:0] SECL_DEV_CODE = 4'h5; // Arbitrary value
   localparam int SECL_PAGE_BYTES = 32'h0000_0010;
   localparam logic [3:0] SECL_BYTE_BITS = 4'h8;
   localparam logic [4:0] SECL_PAGE_SIZE = 5'h10;
   localparam logic [7:0] SECL_IDLE_BYTE = 8'hFF;

   // Control byte fields
   localparam int SECL_CODE_MSB = 32'h0000_0007;
   localparam int SECL_CODE_LSB = 32'h0000_0004;
   localparam int SECL_CS_MSB = 32'h0000_0003;
   localparam int SECL_CS_LSB = 32'h0000_0001;
   localparam int SECL_CS_TOP = 32'h0000_0003;
   localparam int SECL_RW_BIT = 32'h0000_0000;

   // -----------------------------------------------------------------
   // Timing
   // -----------------------------------------------------------------
   localparam int SECL_CLK_PERIOD_NS = 32'h0000_0005;
   // Self-timed write cycle, 5 ms
   localparam int SECL_WRITE_TIME_NS = 32'h004C_4B40;
   localparam int SECL_WRITE_CYCLES =
      (SECL_WRITE_TIME_NS + SECL_CLK_PERIOD_NS - 1) / SECL_CLK_PERIOD_NS;
   // Bus clock made by the master end, 2500 ns period
   localparam int SECL_SCL_PERIOD_NS = 32'h0000_09C4;
   localparam int SECL_SCL_QUARTER = SECL_SCL_PERIOD_NS / (4 * SECL_CLK_PERIOD_NS);

   // -----------------------------------------------------------------
   // Master operations
   // -----------------------------------------------------------------
   typedef enum logic [1:0] {
      SECL_OP_CTRL = 2'h0,
      SECL_OP_WRITE = 2'h1,
      SECL_OP_READ = 2'h2,
      SECL_OP_STOP = 2'h3
   } secl_op_t;

endpackage

// ==== logic/secl_if.sv ====
`timescale 1ns/1ps
interface secl_if;
   logic scl;
   logic mstSdaOe;
   logic mstSdaOut;
   logic devSdaOe;
   logic devSdaOut;
   logic sda;

   // Open-drain data line with pull-up
   assign sda = !((mstSdaOe && !mstSdaOut) || (devSdaOe && !devSdaOut));

   modport master (output scl, output mstSdaOe, output mstSdaOut, input sda);
   modport device (input scl, input sda, output devSdaOe, output devSdaOut);
endinterface

// ==== logic/secl_device.sv ====
`timescale 1ns/1ps
// Operation
// RL1: Respond only to matching code and chip-select
// RL2: Master maps chip-select bits to address 10:8
// RL3: Sequential read stays inside this device
// RL4: Two-select variant sends top select bit zero
// RL5: Acknowledge matching control byte on ninth clock
// RL6: Byte after write control loads pointer
// RL7: Stop starts write cycle; no acknowledges meanwhile
// RL8: Protected writes acknowledged but memory unchanged
// RL9: Master waits write time even when protected
// RL10: Up to sixteen bytes buffered, committed at Stop
// RL11: Increment only low four pointer bits
// RL12: Over sixteen bytes overwrite earlier buffered bytes
// RL13: Master keeps page writes inside one page
// RL14: Protect input high blocks whole array
// RL15: Master polls with Start and write control
// RL16: Acknowledge polling byte once write finishes
// RL17: Read control byte acknowledged then data sent
// RL18: Current read uses last address plus one
// RL19: Unacknowledged byte then Stop ends transmission
// RL20: Repeated Start abandons write, keeps pointer
// RL21: Master acknowledge advances to next byte
// RL22: Pointer increments and wraps FFh to 00h
// RL23: Write cycle length is a fixed parameter
module secl_device
   import secl_pkg::*;
#(
   parameter int WRITE_CYCLES = SECL_WRITE_CYCLES
) (
   input wire logic clk_sys,
   input wire logic nrst,
   input wire logic clkEn,
   secl_if.device bus,
   input wire logic [2:0] chipSelect,
   input wire logic writeProtect,
   output logic writeBusy
);

   // -----------------------------------------------------------------
   // State
   // -----------------------------------------------------------------
   typedef enum logic [2:0] {
      ST_IDLE = 3'h0,
      ST_RX = 3'h1,
      ST_ACK = 3'h2,
      ST_TX = 3'h3,
      ST_MACK = 3'h4
   } secl_dev_st_t;

   typedef enum logic [1:0] {
      PH_CTRL = 2'h0,
      PH_ADDR = 2'h1,
      PH_DATA = 2'h2,
      PH_READ = 2'h3
   } secl_phase_t;

   typedef struct packed {
      secl_dev_st_t st;
      secl_phase_t ph;
      logic [1:0] sclSync;
      logic [1:0] sdaSync;
      logic sclPrev;
      logic sdaPrev;
      logic [1:0][2:0] csSync;
      logic [1:0] wpSync;
      logic [7:0] shift;
      logic [3:0] bitCnt;
      logic rw;
      logic masterAck;
      logic [7:0] ptr;
      logic [15:0][7:0] pbuf;
      logic [15:0] pvalid;
      logic [255:0][7:0] mem;
      logic busy;
      logic [31:0] timer;
      logic sdaOe;
      logic sdaOut;
   } secl_dev_state_t;

   secl_dev_state_t s;
   secl_dev_state_t next_s;

   logic scl;
   logic sda;
   logic sclRise;
   logic sclFall;
   logic startCond;
   logic stopCond;

   assign scl = s.sclSync[1];
   assign sda = s.sdaSync[1];
   assign sclRise = scl && !s.sclPrev;
   assign sclFall = !scl && s.sclPrev;
   assign startCond = scl && s.sclPrev && s.sdaPrev && !sda;
   assign stopCond = scl && s.sclPrev && !s.sdaPrev && sda;

   // -----------------------------------------------------------------
   // Next state
   // -----------------------------------------------------------------
   always_comb begin
      logic doAck;
      logic doLoad;
      doAck = 1'b0;
      doLoad = 1'b0;
      next_s = s;
      next_s.sclSync = {s.sclSync[0], bus.scl};
      next_s.sdaSync = {s.sdaSync[0], bus.sda};
      next_s.sclPrev = s.sclSync[1];
      next_s.sdaPrev = s.sdaSync[1];
      next_s.csSync = {s.csSync[0], chipSelect};
      next_s.wpSync = {s.wpSync[0], writeProtect};

      // Write timer runs on the system clock, not the bus clock
      if (s.busy) begin
         next_s.timer = s.timer - 32'h0000_0001; // RL23
         if (s.timer <= 32'h0000_0001) begin
            next_s.busy = 1'b0; // RL16
         end
      end

      if (startCond) begin
         // A repeated Start drops buffered data but keeps the pointer
         next_s.pvalid = '0; // RL20
         next_s.bitCnt = '0;
         next_s.sdaOe = 1'b0;
         next_s.ph = PH_CTRL;
         next_s.st = s.busy ? ST_IDLE : ST_RX; // RL7
      end else if (stopCond) begin
         next_s.st = ST_IDLE;
         next_s.sdaOe = 1'b0; // RL19
         if (s.ph == PH_DATA && |s.pvalid) begin
            next_s.busy = 1'b1; // RL7
            next_s.timer = WRITE_CYCLES[31:0]; // RL9
            next_s.pvalid = '0;
            if (!s.wpSync[1]) begin // RL8 RL14
               for (int i = 0; i < SECL_PAGE_BYTES; i++) begin
                  if (s.pvalid[i]) begin
                     next_s.mem[{s.ptr[7:4], i[3:0]}] = s.pbuf[i]; // RL10
                  end
               end
            end
         end
      end else begin
         unique case (s.st)
            ST_IDLE: begin
            end
            ST_RX: begin
               if (sclRise) begin
                  next_s.shift = {s.shift[6:0], sda};
                  next_s.bitCnt = s.bitCnt + 4'h1;
               end else if (sclFall && s.bitCnt == SECL_BYTE_BITS) begin
                  next_s.bitCnt = '0;
                  unique case (s.ph)
                     PH_CTRL: begin
                        if (s.shift[SECL_CODE_MSB:SECL_CODE_LSB] == SECL_DEV_CODE &&
                            s.shift[SECL_CS_MSB:SECL_CS_LSB] == s.csSync[1]) begin // RL1
                           next_s.rw = s.shift[SECL_RW_BIT]; // RL17
                           doAck = 1'b1; // RL5
                        end else begin
                           next_s.st = ST_IDLE;
                        end
                     end
                     PH_ADDR: begin
                        next_s.ptr = s.shift; // RL6
                        doAck = 1'b1;
                     end
                     PH_DATA: begin
                        // Low nibble wraps, so a long page overwrites its own entries
                        next_s.pbuf[s.ptr[3:0]] = s.shift; // RL12
                        next_s.pvalid[s.ptr[3:0]] = 1'b1;
                        next_s.ptr[3:0] = s.ptr[3:0] + 4'h1; // RL11
                        doAck = 1'b1;
                     end
                     PH_READ: begin
                        next_s.st = ST_IDLE;
                     end
                  endcase
               end
            end
            ST_ACK: begin
               if (sclFall) begin
                  next_s.sdaOe = 1'b0;
                  if (s.ph == PH_CTRL && s.rw) begin
                     next_s.ph = PH_READ;
                     doLoad = 1'b1; // RL17 RL18
                  end else begin
                     next_s.st = ST_RX;
                     next_s.ph = (s.ph == PH_CTRL) ? PH_ADDR : PH_DATA;
                  end
               end
            end
            ST_TX: begin
               if (sclRise) begin
                  next_s.bitCnt = s.bitCnt + 4'h1;
               end else if (sclFall) begin
                  if (s.bitCnt == SECL_BYTE_BITS) begin
                     next_s.sdaOe = 1'b0;
                     next_s.st = ST_MACK;
                  end else begin
                     next_s.shift = {s.shift[6:0], 1'b0};
                     next_s.sdaOe = !s.shift[6];
                  end
               end
            end
            ST_MACK: begin
               if (sclRise) begin
                  next_s.masterAck = !sda;
               end else if (sclFall) begin
                  if (s.masterAck) begin
                     doLoad = 1'b1; // RL21
                  end else begin
                     next_s.st = ST_IDLE; // RL19
                  end
               end
            end
            default: begin
               next_s.st = ST_IDLE;
            end
         endcase
      end

      if (doAck) begin
         next_s.st = ST_ACK;
         next_s.sdaOe = 1'b1;
         next_s.sdaOut = 1'b0;
      end
      if (doLoad) begin
         // Pointer is eight bits, so reads wrap inside this device
         next_s.st = ST_TX;
         next_s.bitCnt = '0;
         next_s.shift = s.mem[s.ptr];
         next_s.sdaOe = !s.mem[s.ptr][7];
         next_s.sdaOut = 1'b0;
         next_s.ptr = s.ptr + 8'h01; // RL22 RL3
      end
   end

   // -----------------------------------------------------------------
   // Registers
   // -----------------------------------------------------------------
   always_ff @(posedge clk_sys or negedge nrst) begin
      if (!nrst) begin
         // Edge finders start at the idle bus level, so no false edge follows reset
         s <= '{st: ST_IDLE, ph: PH_CTRL, sclSync: '1, sdaSync: '1, sclPrev: 1'b1,
                sdaPrev: 1'b1, default: '0};
      end else if (clkEn) begin
         s <= next_s;
      end
   end

   assign bus.devSdaOe = s.sdaOe;
   assign bus.devSdaOut = s.sdaOut;
   assign writeBusy = s.busy;

endmodule

// ==== logic/secl_master.sv ====
`timescale 1ns/1ps
module secl_master
   import secl_pkg::*;
#(
   parameter bit TWO_SELECTS = 1'b0
) (
   input wire logic clk_sys,
   input wire logic nrst,
   input wire logic clkEn,
   secl_if.master bus,
   input wire logic opValid,
   input wire secl_op_t opCode,
   input wire logic [7:0] opData,
   input wire logic opAck,
   output logic opReady,
   output logic opDone,
   output logic opGotAck,
   output logic opRefused,
   output logic [7:0] rdData
);

   // -----------------------------------------------------------------
   // State
   // -----------------------------------------------------------------
   typedef enum logic [1:0] {
      M_IDLE = 2'h0,
      M_START = 2'h1,
      M_BYTE = 2'h2,
      M_STOP = 2'h3
   } secl_mst_st_t;

   typedef struct packed {
      secl_mst_st_t st;
      logic [7:0] div;
      logic [1:0] q;
      logic [3:0] bitIdx;
      logic [7:0] tx;
      logic [7:0] ctrlByte;
      logic [7:0] rx;
      logic isRead;
      logic isCtrl;
      logic sendAck;
      logic gotAck;
      logic [1:0] sdaSync;
      logic sclOut;
      logic sdaOe;
      logic sdaOut;
      logic wrPending;
      logic addrNext;
      logic wrData;
      logic dataSent;
      logic [4:0] pageLeft;
      logic ready;
      logic done;
      logic doneAck;
      logic refused;
      logic [7:0] rdData;
   } secl_mst_state_t;

   localparam logic [7:0] QUARTER_LAST = 8'(SECL_SCL_QUARTER - 1);

   secl_mst_state_t s;
   secl_mst_state_t next_s;
   logic tick;

   assign tick = (s.div == QUARTER_LAST);

   // -----------------------------------------------------------------
   // Next state
   // -----------------------------------------------------------------
   always_comb begin
      logic [2:0] cs;
      cs = opData[3:1];
      // Chip-select bits carry address bits 10:8
      if (TWO_SELECTS) begin
         cs[2] = 1'b0; // RL4
      end
      next_s = s;
      next_s.done = 1'b0;
      next_s.sdaSync = {s.sdaSync[0], bus.sda};
      if (s.st != M_IDLE) begin
         next_s.div = tick ? 8'h00 : s.div + 8'h01;
      end
      if (s.st != M_IDLE && tick) begin
         next_s.q = s.q + 2'h1;
      end

      unique case (s.st)
         M_IDLE: begin
            if (opValid && s.ready) begin
               next_s.ready = 1'b0;
               next_s.refused = 1'b0;
               next_s.div = '0;
               next_s.q = '0;
               unique case (opCode)
                  SECL_OP_CTRL: begin
                     next_s.ctrlByte = {SECL_DEV_CODE, cs, opData[0]}; // RL2
                     next_s.isCtrl = 1'b1;
                     next_s.isRead = 1'b0;
                     next_s.st = M_START;
                  end
                  SECL_OP_WRITE: begin
                     next_s.isRead = 1'b0;
                     next_s.tx = opData;
                     next_s.bitIdx = '0;
                     next_s.st = M_BYTE;
                     if (s.addrNext) begin
                        next_s.addrNext = 1'b0;
                        next_s.wrData = 1'b1;
                        next_s.pageLeft = SECL_PAGE_SIZE - {1'b0, opData[3:0]};
                     end else if (s.wrData) begin
                        if (s.pageLeft == '0) begin
                           // Would run past the page end: refuse, send nothing
                           next_s.st = M_IDLE; // RL13
                           next_s.refused = 1'b1;
                           next_s.done = 1'b1;
                           next_s.ready = 1'b1;
                        end else begin
                           next_s.pageLeft = s.pageLeft - 5'h01;
                           next_s.dataSent = 1'b1;
                        end
                     end
                  end
                  SECL_OP_READ: begin
                     next_s.isRead = 1'b1;
                     next_s.sendAck = opAck;
                     next_s.bitIdx = '0;
                     next_s.st = M_BYTE;
                  end
                  SECL_OP_STOP: begin
                     next_s.st = M_STOP;
                  end
               endcase
            end
         end
         M_START: begin
            if (tick) begin
               unique case (s.q)
                  2'h0: next_s.sdaOe = 1'b0;
                  2'h1: next_s.sclOut = 1'b1;
                  2'h2: next_s.sdaOe = 1'b1;
                  2'h3: begin
                     next_s.sclOut = 1'b0;
                     next_s.tx = s.ctrlByte;
                     next_s.bitIdx = '0;
                     next_s.st = M_BYTE;
                  end
               endcase
            end
         end
         M_BYTE: begin
            if (tick) begin
               unique case (s.q)
                  2'h0: begin
                     if (s.bitIdx < SECL_BYTE_BITS) begin
                        next_s.sdaOe = s.isRead ? 1'b0 : !s.tx[7];
                     end else begin
                        next_s.sdaOe = s.isRead ? s.sendAck : 1'b0;
                     end
                  end
                  2'h1: next_s.sclOut = 1'b1;
                  2'h2: begin
                     if (s.bitIdx < SECL_BYTE_BITS) begin
                        next_s.rx = {s.rx[6:0], s.sdaSync[1]};
                     end else begin
                        next_s.gotAck = !s.sdaSync[1];
                     end
                  end
                  2'h3: begin
                     next_s.sclOut = 1'b0;
                     next_s.tx = {s.tx[6:0], 1'b1};
                     next_s.bitIdx = s.bitIdx + 4'h1;
                     if (s.bitIdx == SECL_BYTE_BITS) begin
                        next_s.sdaOe = 1'b0;
                        if (s.isCtrl && !s.gotAck && s.wrPending) begin
                           next_s.st = M_START; // RL15 RL9
                        end else begin
                           next_s.st = M_IDLE;
                           next_s.done = 1'b1;
                           next_s.ready = 1'b1;
                           next_s.doneAck = s.gotAck;
                           next_s.rdData = s.rx;
                           if (s.isCtrl) begin
                              next_s.isCtrl = 1'b0;
                              next_s.wrPending = s.wrPending && !s.gotAck;
                              next_s.addrNext = s.gotAck && !s.ctrlByte[SECL_RW_BIT];
                              next_s.wrData = 1'b0;
                              next_s.dataSent = 1'b0;
                           end
                        end
                     end
                  end
               endcase
            end
         end
         M_STOP: begin
            if (tick) begin
               unique case (s.q)
                  2'h0: next_s.sdaOe = 1'b1;
                  2'h1: next_s.sclOut = 1'b1;
                  2'h2: next_s.sdaOe = 1'b0;
                  2'h3: begin
                     next_s.st = M_IDLE;
                     next_s.done = 1'b1;
                     next_s.ready = 1'b1;
                     next_s.wrPending = s.wrPending || s.dataSent; // RL9
                     next_s.dataSent = 1'b0;
                     next_s.wrData = 1'b0;
                     next_s.addrNext = 1'b0;
                  end
               endcase
            end
         end
      endcase
   end

   // -----------------------------------------------------------------
   // Registers
   // -----------------------------------------------------------------
   always_ff @(posedge clk_sys or negedge nrst) begin
      if (!nrst) begin
         s <= '{st: M_IDLE, sclOut: 1'b1, ready: 1'b1, default: '0};
      end else if (clkEn) begin
         s <= next_s;
      end
   end

   assign bus.scl = s.sclOut;
   assign bus.mstSdaOe = s.sdaOe;
   assign bus.mstSdaOut = s.sdaOut;
   assign opReady = s.ready;
   assign opDone = s.done;
   assign opGotAck = s.doneAck;
   assign opRefused = s.refused;
   assign rdData = s.rdData;

endmodule

// ==== tb/secl_checker.sv ====
`timescale 1ns/1ps
module secl_checker
   import secl_pkg::*;
#(
   parameter int WRITE_CYCLES = SECL_WRITE_CYCLES
) (
   input wire logic clk_sys,
   input wire logic nrst,
   input wire logic scl,
   input wire logic mstSdaOe,
   input wire logic mstSdaOut,
   input wire logic devSdaOe,
   input wire logic devSdaOut,
   input wire logic sda,
   input wire logic writeBusy
);
   int busyCnt;
   int sclLowCnt;
   int sclHighCnt;

   default clocking cb @(posedge clk_sys);
   endclocking
   default disable iff (!nrst);

   // ----
   // Cycle counters
   // ----
   always_ff @(posedge clk_sys or negedge nrst) begin
      if (!nrst) begin
         busyCnt <= 0;
         sclLowCnt <= 0;
         sclHighCnt <= 0;
      end else begin
         busyCnt <= writeBusy ? busyCnt + 1 : 0;
         sclLowCnt <= scl ? 0 : sclLowCnt + 1;
         sclHighCnt <= scl ? sclHighCnt + 1 : 0;
      end
   end

   sequence stopSeq;
      scl && $rose(sda);
   endsequence

   sequence devTurn;
      $changed(devSdaOe);
   endsequence

   chk_busy_no_ack:
      assert property (writeBusy |-> !devSdaOe)
      else $error("device drives data during write cycle");
   chk_busy_length:
      assert property ($fell(writeBusy) |->
         busyCnt >= WRITE_CYCLES - 1 && busyCnt <= WRITE_CYCLES + 1)
      else $error("write cycle length wrong");
   chk_busy_at_stop:
      assert property ($rose(writeBusy) |-> scl && sda)
      else $error("write cycle began outside a stop");
   chk_turn_time:
      assert property (devTurn |-> !scl && sclLowCnt >= 1 && sclLowCnt <= 10)
      else $error("device data change not just after clock fall");
   chk_dev_hold:
      assert property ($rose(devSdaOe) |=> devSdaOe [*8])
      else $error("device pull too short");
   chk_stop_release:
      assert property (stopSeq |-> !devSdaOe [*8])
      else $error("device holds data after stop");
   chk_scl_high_time:
      assert property ($fell(scl) |-> sclHighCnt >= SECL_SCL_QUARTER - 1)
      else $error("clock high phase too short");
   chk_pull_only:
      assert property ((devSdaOe |-> !devSdaOut) and (mstSdaOe |-> !mstSdaOut))
      else $error("data line driven high");
endmodule

// ==== tb/serial_eeprom_command_logic_tb.sv ====
`timescale 1ns/1ps
module serial_eeprom_command_logic_tb
   import secl_pkg::*;
;
   // Short write cycle, still long enough that the first poll goes unanswered
   localparam int WC = 32'h0000_0BB8;
   logic clk_sys;
   logic nrst;
   logic writeProtect;
   logic writeBusy;
   logic opValid;
   secl_op_t opCode;
   logic [7:0] opData;
   logic opAck;
   logic opReady;
   logic opDone;
   logic opGotAck;
   logic opRefused;
   logic [7:0] rdData;
   logic busyPrev = 1'b0;
   int busyRises = 0;
   int cycles = 0;
   int num_errors = 0;
   int comparisons = 0;

   secl_if secl_if_i ();
   secl_device #(.WRITE_CYCLES(WC)) secl_device_i (
      .clk_sys(clk_sys), .nrst(nrst), .clkEn(1'b1), .bus(secl_if_i.device),
      .chipSelect(3'h5), .writeProtect(writeProtect), .writeBusy(writeBusy));
   secl_master secl_master_i (
      .clk_sys(clk_sys), .nrst(nrst), .clkEn(1'b1), .bus(secl_if_i.master),
      .opValid(opValid), .opCode(opCode), .opData(opData), .opAck(opAck),
      .opReady(opReady), .opDone(opDone), .opGotAck(opGotAck),
      .opRefused(opRefused), .rdData(rdData));
   secl_checker #(.WRITE_CYCLES(WC)) secl_checker_i (
      .clk_sys(clk_sys), .nrst(nrst), .scl(secl_if_i.scl),
      .mstSdaOe(secl_if_i.mstSdaOe), .mstSdaOut(secl_if_i.mstSdaOut),
      .devSdaOe(secl_if_i.devSdaOe), .devSdaOut(secl_if_i.devSdaOut),
      .sda(secl_if_i.sda), .writeBusy(writeBusy));

   initial begin
      clk_sys = 1'b0;
      forever #2.5 clk_sys = ~clk_sys;
   end

   always @(negedge clk_sys) begin
      busyPrev <= writeBusy;
      if (writeBusy === 1'b1 && busyPrev === 1'b0) busyRises++;
      cycles++;
      if (cycles == 32'h0001_86A0) begin
         num_errors++;
         conclude();
      end
   end

   // ----
   // Shared tasks
   // ----
   task automatic conclude();
      if (num_errors == 0 && comparisons > 0) begin
         $display("== PASSED ==");
      end else begin
         $display("== FAILED ==");
      end
      $finish;
   endtask

   task automatic cmp(input string name, input logic [7:0] exp, input logic [7:0] got);
      comparisons++;
      if (got !== exp) begin
         num_errors++;
         $display("BAD %s expected %h seen %h", name, exp, got);
      end
   endtask

   task automatic op(input secl_op_t c, input logic [7:0] d, input logic a);
      int n;
      // Let one edge pass so a request never follows its own release in one step
      @(negedge clk_sys);
      for (n = 0; n < 9 && opReady !== 1'b1; n++) @(negedge clk_sys);
      opValid = 1'b1;
      opCode = c;
      opData = d;
      opAck = a;
      @(negedge clk_sys);
      opValid = 1'b0;
      for (n = 0; n < 40000 && opDone !== 1'b1; n++) @(negedge clk_sys);
      // A missing answer counts as a mismatch; ready returns with done
      cmp("op done ready", 8'h03, {6'h00, opReady, opDone});
   endtask

   // ----
   // Scenarios
   // ----
   task automatic pageWrite();
      op(SECL_OP_CTRL, 8'h0A, 1'b0);
      cmp("control ack", 8'h01, {7'h00, opGotAck});
      op(SECL_OP_WRITE, 8'h0E, 1'b0);
      cmp("address ack", 8'h01, {7'h00, opGotAck});
      op(SECL_OP_WRITE, 8'hA1, 1'b0);
      op(SECL_OP_WRITE, 8'hB2, 1'b0);
      cmp("page byte ack", 8'h01, {7'h00, opGotAck});
      op(SECL_OP_STOP, 8'h00, 1'b0);
      cmp("busy after stop", 8'h01, {7'h00, writeBusy});
   endtask

   task automatic protWrite();
      writeProtect = 1'b1;
      op(SECL_OP_CTRL, 8'h0A, 1'b0);
      cmp("poll ack", 8'h01, {7'h00, opGotAck});
      op(SECL_OP_WRITE, 8'h0F, 1'b0);
      op(SECL_OP_WRITE, 8'h55, 1'b0);
      cmp("protected ack", 8'h01, {7'h00, opGotAck});
      op(SECL_OP_WRITE, 8'h66, 1'b0);
      cmp("page cross refused", 8'h01, {7'h00, opRefused});
      op(SECL_OP_STOP, 8'h00, 1'b0);
   endtask

   task automatic randRead();
      writeProtect = 1'b0;
      op(SECL_OP_CTRL, 8'h0A, 1'b0);
      cmp("poll ack", 8'h01, {7'h00, opGotAck});
      op(SECL_OP_WRITE, 8'h0E, 1'b0);
      op(SECL_OP_CTRL, 8'h0B, 1'b0);
      cmp("read control ack", 8'h01, {7'h00, opGotAck});
      op(SECL_OP_READ, 8'h00, 1'b0);
      cmp("random byte", 8'hA1, rdData);
      op(SECL_OP_STOP, 8'h00, 1'b0);
      cmp("no cycle after read", 8'h00, {7'h00, writeBusy});
   endtask

   task automatic curRead();
      op(SECL_OP_CTRL, 8'h0B, 1'b0);
      op(SECL_OP_READ, 8'h00, 1'b1);
      cmp("current byte", 8'hB2, rdData);
      op(SECL_OP_READ, 8'h00, 1'b0);
      cmp("next byte", 8'h00, rdData);
      op(SECL_OP_STOP, 8'h00, 1'b0);
   endtask

   task automatic wrongSel();
      op(SECL_OP_CTRL, 8'h04, 1'b0);
      cmp("foreign select ack", 8'h00, {7'h00, opGotAck});
      op(SECL_OP_STOP, 8'h00, 1'b0);
   endtask

   initial begin
      nrst = 1'b0;
      writeProtect = 1'b0;
      opValid = 1'b0;
      opCode = SECL_OP_CTRL;
      opData = 8'h00;
      opAck = 1'b0;
      repeat (6) @(negedge clk_sys);
      nrst = 1'b1;
      pageWrite();
      protWrite();
      randRead();
      curRead();
      wrongSel();
      cmp("write cycles", 8'h02, busyRises[7:0]);
      conclude();
   end
endmodule
